// ---- rtl/sfmr_pkg.sv ----
// sfmr_pkg: target and stage identifier codes, port widths and decode helpers
// for the shared function message router. assumes a single 100 MHz clock domain.
package sfmr_pkg;

  localparam int unsigned SFMR_ID_W = 4;

  // shared target identifiers
  localparam logic [3:0] SFMR_NULL_TARGET = 4'h0;
  localparam logic [3:0] SFMR_TEXTURE_TARGET = 4'h2;
  localparam logic [3:0] SFMR_MESSAGE_GATEWAY_TARGET = 4'h3;
  localparam logic [3:0] SFMR_DATA_PORT_TWO = 4'h4;
  localparam logic [3:0] SFMR_RENDER_PORT = 4'h5;
  localparam logic [3:0] SFMR_RETURN_BUFFER_TARGET = 4'h6;
  localparam logic [3:0] SFMR_SPAWNER_TARGET = 4'h7;
  localparam logic [3:0] SFMR_MOTION_SEARCH_UNIT = 4'h8;
  localparam logic [3:0] SFMR_READ_ONLY_PORT = 4'h9;
  localparam logic [3:0] SFMR_DATA_PORT_ZERO = 4'ha;
  localparam logic [3:0] SFMR_ATTRIBUTE_INTERPOLATOR = 4'hb;
  localparam logic [3:0] SFMR_DATA_PORT_ONE = 4'hc;
  localparam logic [3:0] SFMR_MOTION_REFINEMENT_UNIT = 4'hd;

  // pipeline stage identifiers
  localparam logic [3:0] SFMR_NULL_STAGE = 4'h0;
  localparam logic [3:0] SFMR_HULL_SHADER = 4'h4;
  localparam logic [3:0] SFMR_DOMAIN_SHADER = 4'h5;
  localparam logic [3:0] SFMR_SPAWNER_STAGE = 4'h7;
  localparam logic [3:0] SFMR_VIDEO_FRONT_STAGE = 4'h8;
  localparam logic [3:0] SFMR_VIDEO_FRONT_STAGE_ALT = 4'hd;
  localparam logic [3:0] SFMR_VERTEX_SHADER = 4'h9;
  localparam logic [3:0] SFMR_COMMAND_STREAMER = 4'ha;
  localparam logic [3:0] SFMR_VERTEX_FETCH = 4'hb;
  localparam logic [3:0] SFMR_GEOMETRY_SHADER = 4'hc;
  localparam logic [3:0] SFMR_STRIP_FAN_UNIT = 4'he;
  localparam logic [3:0] SFMR_WINDOWER_MASKER = 4'hf;

  // one-hot target select lanes, 16 wide indexed by code
  localparam int unsigned SFMR_LANES = 16;
  // the three data cache ports share one logical lane
  localparam logic [3:0] SFMR_DATA_CACHE_LANE = SFMR_DATA_PORT_ZERO;

  // a target code is valid unless null or reserved
  function automatic logic sfmr_target_valid(input logic [3:0] id);
    sfmr_target_valid = !(id == 4'h0 || id == 4'h1 || id == 4'he || id == 4'hf);
  endfunction

  // a stage code is valid for thread starts
  function automatic logic sfmr_stage_valid(input logic [3:0] id);
    sfmr_stage_valid = (id == SFMR_HULL_SHADER) || (id == SFMR_DOMAIN_SHADER) ||
      (id == SFMR_SPAWNER_STAGE) || (id == SFMR_VIDEO_FRONT_STAGE) ||
      (id == SFMR_VIDEO_FRONT_STAGE_ALT) || (id >= SFMR_VERTEX_SHADER && id != 4'hd);
  endfunction

  // data cache ports 0,1,2 fold onto one lane
  function automatic logic [3:0] sfmr_lane_of(input logic [3:0] id);
    if (id == SFMR_DATA_PORT_ONE || id == SFMR_DATA_PORT_TWO)
      sfmr_lane_of = SFMR_DATA_CACHE_LANE;
    else
      sfmr_lane_of = id;
  endfunction

endpackage

// ---- rtl/sfmr_dispatch_arb.sv ----
// sfmr_dispatch_arb: round-robin arbiter for thread-start requests.
// assumes requests hold until granted; same clock as the router.
`timescale 1ns/1ps
`default_nettype none
module sfmr_dispatch_arb
  import sfmr_pkg::*;
#(
  parameter int unsigned N = 4
)(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // request side
  input wire logic [N-1:0] req_i,
  input wire logic advance_i,
  // grant
  output logic [N-1:0] grant_o
);
  typedef struct packed {
    logic [N-1:0] last;
  } sfmr_arb_st_t;

  sfmr_arb_st_t st_r;
  sfmr_arb_st_t st_nxt;
  logic [N-1:0] pick;
  logic found;

  // fairness: search starts just after the last winner
  always_comb
  begin
    pick = '0;
    found = 1'b0;
    for (int k = 1; k <= N; k++)
    begin
      for (int j = 0; j < N; j++)
      begin
        if (!found && st_r.last[(j + N - k) % N] && req_i[j])
        begin
          found = 1'b1;
          pick[j] = 1'b1;
        end
      end
    end
    st_nxt = st_r;
    if (advance_i && found)
      st_nxt.last = pick;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      st_r <= '{last: {1'b1, {(N-1){1'b0}}}};
    else
      st_r <= st_nxt;
  end

  assign grant_o = pick;

  grant_onehot_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $onehot0(grant_o) && ((grant_o & ~req_i) == '0))
    else $error("arbiter grant not one-hot or not requested");
endmodule // sfmr_dispatch_arb
`default_nettype wire

// ---- rtl/sfmr_router.sv ----
// sfmr_router: routes execution unit messages to shared targets, returns
// writebacks, holds threads asleep, and dispatches thread starts.
// assumes targets answer with the writeback register tag they were given.
`timescale 1ns/1ps
`default_nettype none
module sfmr_router
  import sfmr_pkg::*;
#(
  parameter int unsigned THREADS = 8,
  parameter int unsigned STAGES = 4,
  parameter int unsigned OPW = 32,
  parameter int unsigned REGW = 8,
  parameter int unsigned REG_BLOCK = 16
)(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // message issue from execution unit threads
  input wire logic msg_valid_i,
  output logic msg_ready_o,
  input wire logic [$clog2(THREADS)-1:0] msg_thread_i,
  input wire logic [3:0] msg_target_i,
  input wire logic [OPW-1:0] msg_operation_i,
  input wire logic [REGW-1:0] msg_operand_base_i,
  input wire logic [3:0] msg_operand_len_i,
  input wire logic [REGW-1:0] msg_writeback_reg_i,
  input wire logic msg_wants_data_i,
  // outgoing to shared targets
  output logic [SFMR_LANES-1:0] tgt_valid_o,
  input wire logic [SFMR_LANES-1:0] tgt_ready_i,
  output logic [3:0] tgt_id_o,
  output logic [OPW-1:0] tgt_operation_o,
  output logic [REGW-1:0] tgt_operand_base_o,
  output logic [3:0] tgt_operand_len_o,
  output logic [$clog2(THREADS)-1:0] tgt_thread_o,
  output logic [REGW-1:0] tgt_writeback_reg_o,
  output logic msg_bad_target_o,
  // response from shared targets
  input wire logic rsp_valid_i,
  input wire logic [$clog2(THREADS)-1:0] rsp_thread_i,
  input wire logic [REGW-1:0] rsp_reg_i,
  input wire logic [OPW-1:0] rsp_data_i,
  input wire logic rsp_last_i,
  // writeback to general thread registers
  output logic gr_we_o,
  output logic [$clog2(THREADS)-1:0] gr_thread_o,
  output logic [REGW-1:0] gr_reg_o,
  output logic [OPW-1:0] gr_data_o,
  output logic [THREADS-1:0] thread_asleep_o,
  // thread start requests from pipeline stages
  input wire logic [STAGES-1:0] start_req_i,
  input wire logic [STAGES*4-1:0] start_stage_id_i,
  input wire logic [STAGES*OPW-1:0] start_payload_i,
  input wire logic [OPW-1:0] return_buffer_data_i,
  output logic [STAGES-1:0] start_grant_o,
  output logic start_valid_o,
  output logic [3:0] start_stage_o,
  output logic [$clog2(THREADS)-1:0] start_thread_o,
  output logic [REGW-1:0] start_reg_base_o,
  output logic [OPW-1:0] start_init_data_o,
  output logic [OPW-1:0] start_init_buf_o
);
  localparam int unsigned TW = $clog2(THREADS);

  typedef struct packed {
    logic [THREADS-1:0] asleep;
    logic [THREADS-1:0] busy;
    logic gr_we;
    logic [TW-1:0] gr_thread;
    logic [REGW-1:0] gr_reg;
    logic [OPW-1:0] gr_data;
    logic bad;
    logic st_valid;
    logic [3:0] st_stage;
    logic [TW-1:0] st_thread;
    logic [REGW-1:0] st_base;
    logic [OPW-1:0] st_data;
    logic [OPW-1:0] st_buf;
  } sfmr_st_t;

  sfmr_st_t st_r;
  sfmr_st_t st_nxt;

  logic [3:0] lane;
  logic valid_tgt;
  logic is_null;
  logic accept;
  logic [STAGES-1:0] grant;
  logic [TW-1:0] free_thread;
  logic free_found;
  logic [3:0] win_stage;
  logic [OPW-1:0] win_payload;

  ////////////////////////////////////////////////////////////////////////////
  // message decode and issue
  assign lane = sfmr_lane_of(msg_target_i);
  assign valid_tgt = sfmr_target_valid(msg_target_i);
  assign is_null = (msg_target_i == SFMR_NULL_TARGET);

  // a sleeping thread cannot issue; invalid codes drop like null
  always_comb
  begin
    tgt_valid_o = '0;
    if (msg_valid_i && valid_tgt && !st_r.asleep[msg_thread_i])
      tgt_valid_o[lane] = 1'b1;
  end

  assign msg_ready_o = !st_r.asleep[msg_thread_i] &&
    (!valid_tgt || tgt_ready_i[lane]);
  assign accept = msg_valid_i && msg_ready_o;
  assign tgt_id_o = msg_target_i;
  assign tgt_operation_o = msg_operation_i;
  assign tgt_operand_base_o = msg_operand_base_i;
  assign tgt_operand_len_o = msg_operand_len_i;
  assign tgt_thread_o = msg_thread_i;
  assign tgt_writeback_reg_o = msg_writeback_reg_i;

  ////////////////////////////////////////////////////////////////////////////
  // thread start arbitration
  sfmr_dispatch_arb #(.N(STAGES)) u_arb (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(start_req_i),
    .advance_i(free_found),
    .grant_o(grant)
  );

  always_comb
  begin
    free_thread = '0;
    free_found = 1'b0;
    for (int t = THREADS - 1; t >= 0; t--)
    begin
      if (!st_r.busy[t])
      begin
        free_thread = TW'(t);
        free_found = 1'b1;
      end
    end
    win_stage = '0;
    win_payload = '0;
    for (int s = 0; s < STAGES; s++)
    begin
      if (grant[s])
      begin
        win_stage = start_stage_id_i[s*4 +: 4];
        win_payload = start_payload_i[s*OPW +: OPW];
      end
    end
  end

  // stalls all starts while every thread is in use
  assign start_grant_o = free_found ? grant : '0;

  ////////////////////////////////////////////////////////////////////////////
  // state update
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.gr_we = 1'b0;
    st_nxt.st_valid = 1'b0;
    st_nxt.bad = accept && !valid_tgt && !is_null;
    // writeback of returned data
    if (rsp_valid_i)
    begin
      st_nxt.gr_we = 1'b1;
      st_nxt.gr_thread = rsp_thread_i;
      st_nxt.gr_reg = rsp_reg_i;
      st_nxt.gr_data = rsp_data_i;
      if (rsp_last_i)
        st_nxt.asleep[rsp_thread_i] = 1'b0;
    end
    // sleep set after wake so same-cycle sleep wins
    if (accept && valid_tgt && msg_wants_data_i)
      st_nxt.asleep[msg_thread_i] = 1'b1;
    // thread start: claim thread, block registers, init data
    if (free_found && grant != '0 && sfmr_stage_valid(win_stage))
    begin
      st_nxt.busy[free_thread] = 1'b1;
      st_nxt.st_valid = 1'b1;
      st_nxt.st_stage = win_stage;
      st_nxt.st_thread = free_thread;
      st_nxt.st_base = REGW'(free_thread * REG_BLOCK);
      st_nxt.st_data = win_payload;
      st_nxt.st_buf = return_buffer_data_i;
    end
    // a spawner-target message ending a thread frees its slot
    if (accept && msg_target_i == SFMR_SPAWNER_TARGET && !msg_wants_data_i)
      st_nxt.busy[msg_thread_i] = 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign gr_we_o = st_r.gr_we;
  assign gr_thread_o = st_r.gr_thread;
  assign gr_reg_o = st_r.gr_reg;
  assign gr_data_o = st_r.gr_data;
  assign thread_asleep_o = st_r.asleep;
  assign msg_bad_target_o = st_r.bad;
  assign start_valid_o = st_r.st_valid;
  assign start_stage_o = st_r.st_stage;
  assign start_thread_o = st_r.st_thread;
  assign start_reg_base_o = st_r.st_base;
  assign start_init_data_o = st_r.st_data;
  assign start_init_buf_o = st_r.st_buf;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence data_req_s;
    accept && valid_tgt && msg_wants_data_i;
  endsequence

  sleep_on_req_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    data_req_s |=> thread_asleep_o[$past(msg_thread_i)])
    else $error("thread not asleep after data request");
  wake_on_last_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rsp_valid_i && rsp_last_i && !(accept && msg_wants_data_i && valid_tgt)
    |=> !thread_asleep_o[$past(rsp_thread_i)])
    else $error("thread not woken on last response");
  null_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    msg_valid_i && is_null && !st_r.asleep[msg_thread_i] |-> msg_ready_o && tgt_valid_o == '0)
    else $error("null message not dropped quietly");
  dc_fold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    msg_valid_i && (msg_target_i == SFMR_DATA_PORT_ONE) |-> !tgt_valid_o[SFMR_DATA_PORT_ONE])
    else $error("data port one not folded onto port zero");
  route_rb_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tgt_valid_o[SFMR_RETURN_BUFFER_TARGET] |-> msg_target_i == 4'h6)
    else $error("return buffer lane misrouted");
  route_ro_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    msg_valid_i && msg_target_i == 4'h9 && !st_r.asleep[msg_thread_i] |-> tgt_valid_o[9])
    else $error("read-only port not selected");
  wb_delay_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rsp_valid_i |=> gr_we_o && gr_reg_o == $past(rsp_reg_i) && gr_data_o == $past(rsp_data_i))
    else $error("writeback not one cycle after response");
  start_claim_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    start_valid_o |-> st_r.busy[start_thread_o] && start_reg_base_o == REGW'(start_thread_o * REG_BLOCK))
    else $error("started thread not claimed");
endmodule // sfmr_router
`default_nettype wire

// ---- testbench/sfmr_sf_model.sv ----
// sfmr_sf_model: shared target side, two reply beats per data request
// assumes router lanes as in sfmr_pkg and one clock
`timescale 1ns/1ps
`default_nettype none
module sfmr_sf_model
  import sfmr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // target lanes
  input wire logic [SFMR_LANES-1:0] valid_i,
  output logic [SFMR_LANES-1:0] ready_o,
  input wire logic [2:0] thread_i,
  input wire logic [7:0] wb_reg_i,
  input wire logic [31:0] op_i,
  // bench controls
  input wire logic [SFMR_LANES-1:0] stall_i,
  input wire logic reply_i,
  input wire logic [3:0] delay_i,
  // reply beats
  output logic rsp_valid_o,
  output logic [2:0] rsp_thread_o,
  output logic [7:0] rsp_reg_o,
  output logic [31:0] rsp_data_o,
  output logic rsp_last_o
);
  logic [1:0] beats_r;
  logic [3:0] wait_r;
  logic [42:0] msg_r;
  assign ready_o = ~stall_i;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i)
  begin
    rsp_valid_o <= 1'b0;
    // idle lines toggle so a stale beat never reads as good
    {rsp_thread_o, rsp_reg_o, rsp_data_o} <= ~{rsp_thread_o, rsp_reg_o, rsp_data_o};
    rsp_last_o <= ~rsp_last_o;
    if (sys_rst_i)
    begin
      beats_r <= 2'h0;
      wait_r <= 4'h0;
      {rsp_thread_o, rsp_reg_o, rsp_data_o, rsp_last_o} <= '0;
    end
    else if (beats_r == 2'h0 && reply_i && |(valid_i & ready_o))
    begin
      beats_r <= 2'h2;
      wait_r <= delay_i;
      msg_r <= {thread_i, wb_reg_i, op_i};
    end
    else if (beats_r != 2'h0 && wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
    else if (beats_r != 2'h0)
    begin
      rsp_valid_o <= 1'b1;
      rsp_thread_o <= msg_r[42:40];
      rsp_reg_o <= msg_r[39:32] + {7'h0, beats_r == 2'h1};
      rsp_data_o <= msg_r[31:0] + {31'h0, beats_r == 2'h1};
      rsp_last_o <= beats_r == 2'h1;
      beats_r <= beats_r - 2'h1;
    end
  end
endmodule // sfmr_sf_model
`default_nettype wire

// ---- testbench/sfmr_router_test.sv ----
// sfmr_router_test: directed bench for the message router
// assumes sfmr_sf_model on the target side and default parameters
`timescale 1ns/1ps
`default_nettype none
module sfmr_router_test
  import sfmr_pkg::*;
;
  logic core_clk_i, sys_rst_i, msg_valid_i, msg_ready_o, msg_wants_data_i, msg_bad_target_o;
  logic rsp_valid_i, rsp_last_i, gr_we_o, start_valid_o, reply;
  logic [2:0] msg_thread_i, tgt_thread_o, rsp_thread_i, gr_thread_o, start_thread_o;
  logic [3:0] msg_target_i, msg_operand_len_i, tgt_id_o, tgt_operand_len_o, start_stage_o;
  logic [3:0] start_req_i, start_grant_o;
  logic [7:0] msg_operand_base_i, msg_writeback_reg_i, tgt_operand_base_o, tgt_writeback_reg_o;
  logic [7:0] rsp_reg_i, gr_reg_o, start_reg_base_o, thread_asleep_o;
  logic [31:0] msg_operation_i, tgt_operation_o, rsp_data_i, gr_data_o, return_buffer_data_i;
  logic [31:0] start_init_data_o, start_init_buf_o;
  logic [15:0] tgt_valid_o, tgt_ready_i, stall, start_stage_id_i;
  logic [127:0] start_payload_i;
  int miscompares, n_compared;

  sfmr_router dut (.*);

  sfmr_sf_model sf (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .valid_i(tgt_valid_o),
    .ready_o(tgt_ready_i), .thread_i(tgt_thread_o), .wb_reg_i(tgt_writeback_reg_o),
    .op_i(tgt_operation_o), .stall_i(stall), .reply_i(reply), .delay_i(4'h3),
    .rsp_valid_o(rsp_valid_i), .rsp_thread_o(rsp_thread_i), .rsp_reg_o(rsp_reg_i),
    .rsp_data_o(rsp_data_i), .rsp_last_o(rsp_last_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(negedge core_clk_i);
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // data ports two and one fold onto the port zero lane
  function automatic logic [15:0] exp_lane(input logic [3:0] c);
    if (c <= 4'h1 || c >= 4'he)
      return 16'h0;
    return (c == 4'h4 || c == 4'hc) ? 16'h0400 : 16'h0001 << c;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // leaves msg_valid_i high so callers can chain back to back
  task automatic send(input logic [2:0] thr, input logic [3:0] code, input logic wants);
    int k;
    msg_valid_i = 1'b1;
    msg_thread_i = thr;
    msg_target_i = code;
    msg_wants_data_i = wants;
    msg_operation_i = {28'h0, code} + 32'h100;
    msg_writeback_reg_i = {5'h0, thr} + 8'h20;
    #1;
    for (k = 0; k < 20 && msg_ready_o !== 1'b1; k++)
    begin
      tick();
      #1;
    end
    chk("msg_ready", 1, msg_ready_o);
    chk("tgt_valid", exp_lane(code), tgt_valid_o);
    if (exp_lane(code) != 16'h0)
      chk("tgt_fields", {tgt_id_o, tgt_thread_o, tgt_writeback_reg_o, tgt_operation_o,
        tgt_operand_base_o, tgt_operand_len_o},
        {code, thr, msg_writeback_reg_i, msg_operation_i, 8'h3c, 4'h5});
    tick();
    chk("bad_target", code == 4'h1 || code >= 4'he, msg_bad_target_o);
    chk("asleep", wants && exp_lane(code) != 16'h0, thread_asleep_o[thr]);
  endtask

  task automatic data_request();
    int k;
    reply = 1'b1;
    send(3'h5, SFMR_TEXTURE_TARGET, 1'b1);
    reply = 1'b0;
    msg_target_i = SFMR_RENDER_PORT;
    #1;
    chk("ready_asleep", 0, msg_ready_o);
    msg_thread_i = 3'h6;
    stall = 16'h0020;
    #1;
    chk("ready_stall", 0, msg_ready_o);
    msg_valid_i = 1'b0;
    for (k = 0; k < 30 && gr_we_o !== 1'b1; k++)
      tick();
    chk("wb_first", {1'b1, 3'h5, 8'h25, 32'h102}, {gr_we_o, gr_thread_o, gr_reg_o, gr_data_o});
    chk("asleep_mid", 1, thread_asleep_o[5]);
    tick();
    chk("wb_last", {1'b1, 8'h26, 32'h103}, {gr_we_o, gr_reg_o, gr_data_o});
    tick();
    chk("asleep_end", 0, thread_asleep_o[5]);
    stall = 16'h0;
  endtask

  task automatic start_one(input logic [3:0] code);
    int k;
    logic ok;
    tick();
    ok = !(code <= 4'h3 || code == 4'h6);
    start_stage_id_i = {4{code}};
    start_payload_i = {4{32'h500 + {28'h0, code}}};
    start_req_i = 4'h1 << code[1:0];
    #1;
    for (k = 0; k < 10 && start_grant_o !== start_req_i; k++)
    begin
      tick();
      #1;
    end
    chk("grant", start_req_i, start_grant_o);
    tick();
    start_req_i = 4'h0;
    chk("start_valid", ok, start_valid_o);
    if (ok)
    begin
      chk("start_stage", code, start_stage_o);
      chk("reg_base", {start_thread_o, 4'h0}, start_reg_base_o);
      chk("init", {start_init_buf_o, start_init_data_o},
        {return_buffer_data_i, start_payload_i[31:0]});
      send(start_thread_o, SFMR_SPAWNER_TARGET, 1'b0);
      msg_valid_i = 1'b0;
    end
  endtask

  task automatic concurrent_starts();
    int k;
    logic [3:0] seen, g;
    tick();
    seen = 4'h0;
    start_stage_id_i = 16'h9ca5;
    start_req_i = 4'hf;
    for (k = 0; k < 8 && seen != 4'hf; k++)
    begin
      #1;
      g = start_grant_o;
      chk("grant_onehot", 1, $onehot(g));
      seen = seen | g;
      tick();
      chk("start_burst", 1, start_valid_o);
      start_req_i = start_req_i & ~g;
    end
    chk("grants_seen", 4'hf, seen);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    miscompares = 0;
    n_compared = 0;
    sys_rst_i = 1'b1;
    {msg_valid_i, msg_wants_data_i, reply, msg_thread_i, msg_target_i} = '0;
    {msg_operation_i, msg_writeback_reg_i, start_req_i, start_stage_id_i, stall} = '0;
    msg_operand_base_i = 8'h3c;
    msg_operand_len_i = 4'h5;
    start_payload_i = '0;
    return_buffer_data_i = 32'hcafe_0123;
    repeat (2) @(posedge core_clk_i);
    tick();
    sys_rst_i = 1'b0;
    chk("reset_outs", 0, {thread_asleep_o, gr_we_o, start_valid_o, msg_bad_target_o});
    // every code in turn, back to back; null and reserved ask for data
    for (int c = 0; c < 16; c++)
      send(c[2:0], c[3:0], c <= 1 || c >= 14);
    msg_valid_i = 1'b0;
    data_request();
    for (int c = 0; c < 16; c++)
      start_one(c[3:0]);
    concurrent_starts();
    finish_test();
  end
endmodule // sfmr_router_test
`default_nettype wire
